/* core/psd_pkg.sv */
package psd_pkg;
    localparam int CHANNELS  = 4;
    localparam int CMP_UNITS = 8;
    localparam int CNT_W     = 16;
    localparam int PER_W     = 4;
    localparam int BUF_DEPTH = 2;

    localparam logic [1:0] METHOD_MANUAL = 2'h0;
    localparam logic [1:0] METHOD_DMA    = 2'h2;

    // Mask and status bit positions
    localparam int MSK_WRITE_READY_FLAG  = 0;
    localparam int MSK_TRANSFER_END_FLAG = 1;
    localparam int MSK_BUFE  = 2;
    localparam int MSK_UNDERRUN_FLAG  = 3;
    localparam int MSK_CMPM  = 8;
    localparam int MSK_CMPU  = 16;
    localparam int MSK_W     = 24;

    localparam logic [CNT_W-1:0] DUTY_RST = 16'h0000;
    localparam logic [PER_W-1:0] PER_RST  = 4'h0;
endpackage : psd_pkg

/* core/psd_buf.sv */
`timescale 1ns/1ps
`default_nettype none
module psd_buf
    import psd_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic [CNT_W-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic [CNT_W-1:0]      out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    logic [CNT_W-1:0] slot_reg [BUF_DEPTH];
    logic [1:0]       cnt_reg;
    logic [1:0]       cnt_next;
    wire              push = in_valid_in & in_ready_out;
    wire              pop  = out_valid_out & out_ready_in;

    assign out_valid_out = cnt_reg != 2'h0;
    assign out_data_out  = slot_reg[0];
    assign cnt_next      = cnt_reg + {1'b0, push} - {1'b0, pop};

    // Ready is registered so the source sees a clean flop output
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_reg      <= 2'h0;
            in_ready_out <= 1'b1;
        end else begin
            cnt_reg      <= cnt_next;
            in_ready_out <= cnt_next != 2'h2;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            slot_reg[0] <= DUTY_RST;
            slot_reg[1] <= DUTY_RST;
        end else if (pop) begin
            slot_reg[0] <= (cnt_reg == 2'h2) ? slot_reg[1] : in_data_in;
        end else if (push && cnt_reg == 2'h0) begin
            slot_reg[0] <= in_data_in;
        end else if (push) begin
            slot_reg[1] <= in_data_in;
        end
    end
endmodule : psd_buf
`default_nettype wire

/* core/psd_sync_update.sv */
`timescale 1ns/1ps
`default_nettype none
module psd_sync_update
    import psd_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                nrst_in,
    input  wire logic [1:0]          sync_update_method_in,
    input  wire logic [CHANNELS-1:0] channel_is_synchronous_in,
    input  wire logic                request_timing_select_in,
    input  wire logic [2:0]          request_comparison_select_in,
    input  wire logic                channel_zero_enable_in,
    input  wire logic                update_unlock_set_in,
    input  wire logic [PER_W-1:0]    update_period_value_in,
    input  wire logic                update_period_wr_in,
    input  wire logic                period_end_in,
    input  wire logic [CNT_W-1:0]    counter_in,
    input  wire logic                counter_down_in,
    input  wire logic                center_alignment_in,
    input  wire logic                fault_active_in,
    input  wire logic [CNT_W-1:0]    dma_data_in,
    input  wire logic                dma_valid_in,
    output logic                     dma_ready_out,
    output logic                     dma_request_out,
    input  wire logic                dma_transfer_done_in,
    input  wire logic                dma_buffer_empty_in,
    input  wire logic                status_read_in,
    input  wire logic [MSK_W-1:0]    second_interrupt_mask_in,
    input  wire logic [2:0]          cmp_select_in,
    input  wire logic                cmp_value_wr_in,
    input  wire logic [CNT_W-1:0]    cmp_value_data_in,
    input  wire logic                cmp_direction_in,
    input  wire logic [PER_W-1:0]    cmp_trigger_in,
    input  wire logic [PER_W-1:0]    cmp_period_max_in,
    input  wire logic                cmp_mode_wr_in,
    input  wire logic                cmp_enable_in,
    input  wire logic [PER_W-1:0]    cmp_update_period_in,
    output logic                     update_unlock_out,
    output logic                     period_deadtime_load_out,
    output logic                     duty_load_out,
    output logic [CHANNELS-1:0][CNT_W-1:0] duty_value_out,
    output logic [PER_W-1:0]         update_period_active_out,
    output logic                     write_ready_flag_out,
    output logic                     transfer_end_flag_out,
    output logic                     dma_buffer_empty_flag_out,
    output logic                     underrun_flag_out,
    output logic [CMP_UNITS-1:0]     cmp_match_out,
    output logic [CMP_UNITS-1:0]     cmp_match_flag_out,
    output logic [CMP_UNITS-1:0]     cmp_update_flag_out,
    output logic                     irq_out
);
    function automatic logic [1:0] psd_slot(input logic [CHANNELS-1:0] m,
                                            input logic [2:0] k);
        logic [2:0] seen;
        logic [1:0] r;
        seen = 3'h0;
        r    = 2'h0;
        for (int j = 0; j < CHANNELS; j++) begin
            if (m[j]) begin
                if (seen == k) begin
                    r = j[1:0];
                end
                seen = seen + 3'h1;
            end
        end
        return r;
    endfunction : psd_slot

    function automatic logic [2:0] psd_count(input logic [CHANNELS-1:0] m);
        logic [2:0] n;
        n = 3'h0;
        for (int j = 0; j < CHANNELS; j++) begin
            n = n + {2'h0, m[j]};
        end
        return n;
    endfunction : psd_count

    logic [PER_W-1:0]              upc_reg;
    logic [PER_W-1:0]              upr_shd_reg;
    logic                          upr_pend_reg;
    logic [CHANNELS-1:0][CNT_W-1:0] stage_reg;
    logic [2:0]                    got_reg;
    logic [2:0]                    got_next;
    logic                          req_next;
    logic [CNT_W-1:0]              buf_data;
    logic                          buf_valid;
    logic [CMP_UNITS-1:0]          cmp_upd;

    wire       dma_mode  = sync_update_method_in == METHOD_DMA;
    wire       auto_mode = sync_update_method_in != METHOD_MANUAL;
    wire [2:0] need      = psd_count(channel_is_synchronous_in);
    wire       words_done = got_reg >= need;
    wire       upd_due   = auto_mode & period_end_in
                         & (upc_reg == update_period_active_out);
    wire       pd_apply  = period_end_in & update_unlock_out;
    wire       wr_event  = request_timing_select_in
                         ? cmp_match_out[request_comparison_select_in]
                         : upd_due;
    // Words are held back in the loading cycle so none is lost
    wire       buf_ready = dma_mode & dma_request_out & ~words_done
                         & ~upd_due;
    wire       take      = buf_valid & buf_ready;
    wire [1:0] slot      = psd_slot(channel_is_synchronous_in, got_reg);
    wire       underrun  = upd_due & dma_mode & ~words_done;

    assign got_next = upd_due ? 3'h0 : got_reg + {2'h0, take};
    assign req_next = (dma_mode & wr_event)
                    | (dma_request_out & (got_next < need) & ~upd_due);

    psd_buf u_buf (
        .clk_in       (clk_in),
        .nrst_in      (nrst_in),
        .in_data_in   (dma_data_in),
        .in_valid_in  (dma_valid_in),
        .in_ready_out (dma_ready_out),
        .out_data_out (buf_data),
        .out_valid_out(buf_valid),
        .out_ready_in (buf_ready)
    );

    // A new unlock write in the apply cycle stays set for the next period
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            update_unlock_out        <= 1'b0;
            period_deadtime_load_out <= 1'b0;
        end else begin
            update_unlock_out        <= update_unlock_set_in
                                      | (update_unlock_out & ~pd_apply);
            period_deadtime_load_out <= pd_apply;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            upc_reg                  <= PER_RST;
            update_period_active_out <= PER_RST;
            upr_shd_reg              <= PER_RST;
            upr_pend_reg             <= 1'b0;
        end else begin
            if (upd_due) begin
                upc_reg <= PER_RST;
            end else if (auto_mode && period_end_in) begin
                upc_reg <= upc_reg + 4'h1;
            end
            if (update_period_wr_in) begin
                upr_shd_reg <= update_period_value_in;
            end
            upr_pend_reg <= update_period_wr_in | (upr_pend_reg & ~upd_due);
            if (upd_due && upr_pend_reg) begin
                update_period_active_out <= upr_shd_reg;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stage_reg       <= '0;
            duty_value_out  <= '0;
            duty_load_out   <= 1'b0;
            got_reg         <= 3'h0;
            dma_request_out <= 1'b0;
        end else begin
            if (take) begin
                stage_reg[slot] <= buf_data;
            end
            for (int c = 0; c < CHANNELS; c++) begin
                if (upd_due && channel_is_synchronous_in[c]) begin
                    duty_value_out[c] <= stage_reg[c];
                end
            end
            duty_load_out   <= upd_due;
            got_reg         <= got_next;
            dma_request_out <= req_next;
        end
    end

    // Hardware set wins over a clearing read in the same cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            write_ready_flag_out      <= 1'b0;
            transfer_end_flag_out     <= 1'b0;
            dma_buffer_empty_flag_out <= 1'b0;
            underrun_flag_out         <= 1'b0;
            cmp_match_flag_out        <= '0;
            cmp_update_flag_out       <= '0;
        end else begin
            write_ready_flag_out      <= (auto_mode & wr_event)
                                       | (write_ready_flag_out
                                          & ~status_read_in);
            transfer_end_flag_out     <= dma_transfer_done_in
                                       | (transfer_end_flag_out
                                          & ~status_read_in);
            dma_buffer_empty_flag_out <= dma_buffer_empty_in
                                       | (dma_buffer_empty_flag_out
                                          & ~status_read_in);
            underrun_flag_out         <= underrun
                                       | (underrun_flag_out
                                          & ~status_read_in);
            cmp_match_flag_out        <= cmp_match_out
                                       | (cmp_match_flag_out
                                          & {CMP_UNITS{~status_read_in}});
            cmp_update_flag_out       <= cmp_upd
                                       | (cmp_update_flag_out
                                          & {CMP_UNITS{~status_read_in}});
        end
    end

    wire [MSK_W-1:0] status_vec = {cmp_update_flag_out, cmp_match_flag_out,
                                   4'h0, underrun_flag_out,
                                   dma_buffer_empty_flag_out,
                                   transfer_end_flag_out,
                                   write_ready_flag_out};

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status_vec & second_interrupt_mask_in);
        end
    end

    for (genvar u = 0; u < CMP_UNITS; u++) begin : g_cmp
        logic             cen_reg, sm_cen_reg;
        logic             dir_reg, sv_dir_reg;
        logic [CNT_W-1:0] cv_reg, sv_cv_reg;
        logic [PER_W-1:0] ctr_reg, sv_ctr_reg;
        logic [PER_W-1:0] cpr_reg, sv_cpr_reg;
        logic [PER_W-1:0] comparison_update_period_reg, sm_comparison_update_period_reg;
        logic [PER_W-1:0] comparison_period_counter_reg, comparison_update_counter_reg;
        logic             pend_reg, hit_prev_reg, match_reg, upd_reg;
        wire  sel_u  = cmp_select_in == 3'(u);
        wire  dir_ok = ~center_alignment_in | (counter_down_in == dir_reg);
        wire  hit    = cen_reg & ~fault_active_in & dir_ok
                     & (counter_in == cv_reg) & (comparison_period_counter_reg == ctr_reg);
        // While channel 0 is off there is no period, so load at once
        wire  load   = pend_reg & (~channel_zero_enable_in
                     | (period_end_in & (comparison_update_counter_reg == comparison_update_period_reg)));

        always_ff @(posedge clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                {sv_cv_reg, sv_dir_reg, sv_ctr_reg, sv_cpr_reg} <= '0;
                {sm_cen_reg, sm_comparison_update_period_reg, pend_reg}             <= '0;
            end else begin
                if (cmp_value_wr_in && sel_u) begin
                    {sv_cv_reg, sv_dir_reg}  <= {cmp_value_data_in,
                                                 cmp_direction_in};
                    {sv_ctr_reg, sv_cpr_reg} <= {cmp_trigger_in,
                                                 cmp_period_max_in};
                end
                if (cmp_mode_wr_in && sel_u) begin
                    {sm_cen_reg, sm_comparison_update_period_reg} <= {cmp_enable_in,
                                                  cmp_update_period_in};
                end
                pend_reg <= (cmp_mode_wr_in & sel_u) | (pend_reg & ~load);
            end
        end

        always_ff @(posedge clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                {cen_reg, dir_reg, cv_reg}    <= '0;
                {ctr_reg, cpr_reg, comparison_update_period_reg}  <= '0;
                {comparison_period_counter_reg, comparison_update_counter_reg}     <= '0;
                {hit_prev_reg, match_reg, upd_reg} <= '0;
            end else begin
                if (load) begin
                    {cen_reg, dir_reg, cv_reg}   <= {sm_cen_reg, sv_dir_reg,
                                                     sv_cv_reg};
                    {ctr_reg, cpr_reg, comparison_update_period_reg} <= {sv_ctr_reg, sv_cpr_reg,
                                                     sm_comparison_update_period_reg};
                end
                if (period_end_in) begin
                    comparison_period_counter_reg  <= (comparison_period_counter_reg == cpr_reg) ? PER_RST
                                 : comparison_period_counter_reg + 4'h1;
                    comparison_update_counter_reg <= (comparison_update_counter_reg == comparison_update_period_reg) ? PER_RST
                                 : comparison_update_counter_reg + 4'h1;
                end
                hit_prev_reg <= hit;
                match_reg    <= hit & ~hit_prev_reg;
                upd_reg      <= load;
            end
        end
        assign cmp_match_out[u] = match_reg;
        assign cmp_upd[u]       = upd_reg;

        a_match_fault: assert property (@(posedge clk_in) disable iff (!nrst_in)
            $past(fault_active_in) |-> !match_reg)
            else $error("match during fault");
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    a_unlock_hold: assert property (update_unlock_out && !period_end_in
        |=> update_unlock_out)
        else $error("unlock dropped early");
    a_unlock_apply: assert property (update_unlock_out && period_end_in
        && !update_unlock_set_in |=> period_deadtime_load_out
        && !update_unlock_out)
        else $error("unlock apply wrong");
    a_locked_load: assert property (period_deadtime_load_out
        |-> $past(update_unlock_out))
        else $error("load while locked");
    a_duty_restart: assert property (duty_load_out |-> upc_reg == 4'h0)
        else $error("counter not restarted");
    a_duty_period: assert property (auto_mode && period_end_in
        && upc_reg == update_period_active_out |=> duty_load_out)
        else $error("duty load missed");
    a_underrun_set: assert property (underrun |=> underrun_flag_out)
        else $error("underrun not flagged");
    a_write_ready_flag_clear: assert property (status_read_in && !wr_event
        |=> !write_ready_flag_out)
        else $error("write ready not cleared");
    a_req_timing: assert property (dma_mode && !request_timing_select_in
        && upd_due |=> dma_request_out ##0 write_ready_flag_out)
        else $error("request not raised");
    a_irq_mask: assert property (second_interrupt_mask_in == '0
        && $past(second_interrupt_mask_in) == '0 |-> !irq_out)
        else $error("masked interrupt");
    a_transfer_end_flag_set: assert property (dma_transfer_done_in
        |=> transfer_end_flag_out)
        else $error("transfer end missed");

    c_dma_load: cover property (dma_mode && upd_due && words_done);
    c_underrun: cover property (underrun);
    c_cmp_match: cover property (|cmp_match_out);
    c_unlock: cover property (pd_apply);
endmodule : psd_sync_update
`default_nettype wire

/* sim/psd_dma_model.sv */
`timescale 1ns/1ps
`default_nettype none
module psd_dma_model
    import psd_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic             request_in,
    input  wire logic             ready_in,
    input  wire logic             arm_in,
    input  wire logic             stall_in,
    input  wire logic [CNT_W-1:0] base_in,
    input  wire logic [2:0]       len_in,
    output logic [CNT_W-1:0]      data_out,
    output logic                  valid_out,
    output logic                  done_out,
    output logic                  empty_out
);
    logic [2:0]       left_reg;
    logic [CNT_W-1:0] word_reg;
    assign empty_out = (left_reg == 3'h0);
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {left_reg, word_reg, data_out} <= {3'h0, 16'h0000, 16'h0000};
            {valid_out, done_out} <= 2'h0;
        end else begin
            done_out <= 1'b0;
            if (arm_in) begin
                {left_reg, word_reg} <= {len_in, base_in};
            end else if (valid_out && ready_in) begin
                valid_out <= 1'b0;
                data_out  <= ~data_out;
                left_reg  <= left_reg - 3'h1;
                word_reg  <= word_reg + 16'h0001;
                done_out  <= (left_reg == 3'h1);
            end else if (!valid_out && request_in && left_reg != 3'h0
                         && !stall_in) begin
                {valid_out, data_out} <= {1'b1, word_reg};
            end else if (!valid_out) begin
                // Idle bus toggles so no stale word is mistaken
                data_out <= ~data_out;
            end
        end
    end
endmodule : psd_dma_model
`default_nettype wire

/* sim/psd_sync_update_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module psd_sync_update_bench
    import psd_pkg::*;
();
    logic clk_in, nrst_in, pe, unl, upw, srd, c0en, center_alignment, cdn, flt;
    logic vwr, mwr, cdir, comparison_enable, tsel, arm, stall, dvalid, dready, dreq;
    logic ddone, dempty, unl_o, pdt, dload, write_ready_flag, transfer_end_flag, bufe, underrun_flag, irq;
    logic [1:0] meth;
    logic [2:0] rsel, csel;
    logic [3:0] sync, upv, ctrig, cpmax, comparison_update_period, upa;
    logic [CNT_W-1:0] cnt, cval, base, ddata;
    logic [MSK_W-1:0] mask;
    logic [CHANNELS-1:0][CNT_W-1:0] duty;
    logic [CMP_UNITS-1:0] cm, cmf, cuf;
    logic [15:0] vals [8];
    int num_errors, check_count;
    psd_sync_update uut (.clk_in(clk_in), .nrst_in(nrst_in),
        .sync_update_method_in(meth), .channel_is_synchronous_in(sync),
        .request_timing_select_in(tsel), .request_comparison_select_in(rsel),
        .channel_zero_enable_in(c0en), .update_unlock_set_in(unl),
        .update_period_value_in(upv), .update_period_wr_in(upw),
        .period_end_in(pe), .counter_in(cnt), .counter_down_in(cdn),
        .center_alignment_in(center_alignment), .fault_active_in(flt),
        .dma_data_in(ddata), .dma_valid_in(dvalid), .dma_ready_out(dready),
        .dma_request_out(dreq), .dma_transfer_done_in(ddone),
        .dma_buffer_empty_in(dempty), .status_read_in(srd),
        .second_interrupt_mask_in(mask), .cmp_select_in(csel),
        .cmp_value_wr_in(vwr), .cmp_value_data_in(cval),
        .cmp_direction_in(cdir), .cmp_trigger_in(ctrig),
        .cmp_period_max_in(cpmax), .cmp_mode_wr_in(mwr), .cmp_enable_in(comparison_enable),
        .cmp_update_period_in(comparison_update_period), .update_unlock_out(unl_o),
        .period_deadtime_load_out(pdt), .duty_load_out(dload),
        .duty_value_out(duty), .update_period_active_out(upa),
        .write_ready_flag_out(write_ready_flag), .transfer_end_flag_out(transfer_end_flag),
        .dma_buffer_empty_flag_out(bufe), .underrun_flag_out(underrun_flag),
        .cmp_match_out(cm), .cmp_match_flag_out(cmf),
        .cmp_update_flag_out(cuf), .irq_out(irq));
    psd_dma_model dma (.clk_in(clk_in), .nrst_in(nrst_in), .request_in(dreq),
        .ready_in(dready), .arm_in(arm), .stall_in(stall), .base_in(base),
        .len_in(3'h3), .data_out(ddata), .valid_out(dvalid),
        .done_out(ddone), .empty_out(dempty));
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse
    task automatic period();
        tick(1 + $urandom % 4);
        pulse(pe);
    endtask : period
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task automatic cmp_cfg(input int u, input logic [15:0] v, input logic d, e);
        {csel, cval, cdir, comparison_enable} = {3'(u), v, d, e};
        pulse(vwr);
        pulse(mwr);
        tick(2);
    endtask : cmp_cfg
    task automatic hit(input logic [15:0] v, input logic [7:0] exp);
        logic [7:0] seen;
        cnt = v;
        tick(1);
        seen = cm;
        cnt = 16'hffff;
        tick(1);
        chk(seen | cm, exp);
    endtask : hit
    function automatic logic [15:0] exp_duty(input int ch, input logic [15:0] b);
        logic [15:0] k;
        k = b;
        for (int i = 0; i < ch; i++) k = k + {15'h0000, sync[i]};
        return sync[ch] ? k : DUTY_RST;
    endfunction : exp_duty
    initial begin
        {pe, unl, upw, srd, center_alignment, cdn, flt, vwr, mwr, cdir} = 10'h000;
        {comparison_enable, tsel, arm, stall, nrst_in, c0en} = 6'h01;
        {meth, rsel, csel, sync, upv} = {2'h0, 3'h3, 3'h0, 4'hb, 4'h0};
        {ctrig, cpmax, comparison_update_period, cnt, cval} = {12'h000, 16'hffff, 16'h0000};
        {mask, num_errors, check_count} = {24'h000000, 32'h0, 32'h0};
        base = 16'($urandom(32'hc9504ba2));
        repeat (16) @(negedge clk_in);
        nrst_in = 1'b1;
        chk({dready, unl_o, dreq, write_ready_flag, irq}, 5'h10);
        pulse(pe);
        chk(pdt, 1'b0);
        pulse(unl);
        tick(3);
        chk(unl_o, 1'b1);
        pulse(pe);
        chk({pdt, unl_o}, 2'h2);
        $display("test unlock done");
        {meth, arm} = {METHOD_DMA, 1'b1};
        tick(1);
        arm = 1'b0;
        pulse(pe);
        chk(dreq, 1'b1);
        for (int i = 0; i < 60 && transfer_end_flag !== 1'b1; i++) begin
            stall = 1'($urandom);
            tick(1);
        end
        stall = 1'b0;
        // Timed out: count it and run on to the closing report
        if (transfer_end_flag !== 1'b1) begin
            num_errors++;
        end
        tick(4);
        chk({write_ready_flag, transfer_end_flag, bufe, underrun_flag, irq}, 5'h1e);
        mask[MSK_UNDERRUN_FLAG] = 1'b1;
        tick(2);
        chk(irq, 1'b1);
        pulse(srd);
        chk({write_ready_flag, transfer_end_flag, bufe, underrun_flag}, 4'h2);
        period();
        chk({dload, underrun_flag}, 2'h2);
        for (int c = 0; c < CHANNELS; c++) begin
            chk(duty[c], exp_duty(c, base));
        end
        chk(write_ready_flag, 1'b1);
        upv = 4'h2;
        pulse(upw);
        upv = 4'h1;
        pulse(upw);
        period();
        chk({dload, upa, underrun_flag}, 6'h23);
        period();
        chk(dload, 1'b0);
        period();
        chk(dload, 1'b1);
        $display("test dma update done");
        c0en = 1'b0;
        for (int u = 0; u < CMP_UNITS; u++) begin
            vals[u] = {1'b0, 3'(u), 12'($urandom % 32'h00000f00)};
            cmp_cfg(u, vals[u], 1'b0, 1'b1);
        end
        for (int u = 0; u < CMP_UNITS; u++) begin
            hit(vals[u], 8'h01 << u);
        end
        chk({cmf, cuf}, 16'hffff);
        pulse(srd);
        chk({cmf, cuf}, 16'h0000);
        center_alignment = 1'b1;
        cmp_cfg(0, vals[0], 1'b1, 1'b1);
        hit(vals[0], 8'h00);
        cdn = 1'b1;
        hit(vals[0], 8'h01);
        {cdn, flt} = 2'h1;
        hit(vals[1], 8'h00);
        flt = 1'b0;
        cmp_cfg(2, vals[2], 1'b0, 1'b0);
        hit(vals[2], 8'h00);
        tsel = 1'b1;
        pulse(srd);
        chk(write_ready_flag, 1'b0);
        hit(vals[3], 8'h08);
        tick(2);
        chk(write_ready_flag, 1'b1);
        $display("test compare done");
        wrap_up();
    end
endmodule : psd_sync_update_bench
`default_nettype wire
